/* hw/bpa_pkg.sv */
// Shared constants and types for the burst period average readout block.
package bpa_pkg;
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned TENTH_US_NS   = 100;
  localparam int unsigned AVG_CYCLES    = 10;
  localparam int unsigned DIGITS        = 5;
  localparam int unsigned ID_W          = 4;
  localparam int unsigned MARKS         = 256;
  localparam int unsigned PRESCALE      = AVG_CYCLES * TENTH_US_NS / CLK_PERIOD_NS;
  localparam logic [4:0]  PRESCALE_LAST = 5'(PRESCALE - 1);
  localparam logic [3:0]  EDGE_LAST     = 4'(AVG_CYCLES);
  localparam logic [3:0]  BCD_NINE      = 4'h9;
  localparam logic [3:0]  BCD_ZERO      = 4'h0;
  localparam logic [3:0]  ID_RESET      = 4'h0;
  typedef enum logic [1:0] {ST_IDLE, ST_ARM, ST_COUNT} bpa_state_type;
endpackage

/* hw/bpa_bcd_digit.sv */
// One decade of a cascadable binary coded decimal counter.
`timescale 1ns/1ns
`default_nettype none
module bpa_bcd_digit
  import bpa_pkg::*;
(
  // Clock and control
  input  wire logic       ref_clk_i,
  input  wire logic       resetn_i,
  input  wire logic       ce_i,
  input  wire logic       clr_i,
  input  wire logic       inc_i,
  // Digit value and carry to the next decade
  output logic [3:0]      digit_o,
  output logic            carry_o
);
  assign carry_o = inc_i && (digit_o == BCD_NINE);

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      digit_o <= BCD_ZERO;
    end else if (ce_i) begin
      if (clr_i) begin
        digit_o <= BCD_ZERO;
      end else if (carry_o) begin
        digit_o <= BCD_ZERO;
      end else if (inc_i) begin
        digit_o <= digit_o + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

/* hw/bpa_readout.sv */
// Burst period averaging, selection gating and printer and display readout.
`timescale 1ns/1ns
`default_nettype none
//
// Function
// - Average period over ten subcarrier cycles.
// - Result goes to printer in BCD.
// - Print carries sequence, frame, channel numbers.
// - Show each selected result on five-digit display.
// - Quantity is period in microseconds.
// - 289 selection bits gate the readout.
// - Readout keeps up with 55 bursts/second.
// - Lock mode processes digital and analog.
// - Search mode processes analog only.
// - One to sixteen channels and frames.
// - 256 bits gate individual channel marks.
// - Five digits, tenth microsecond resolution.
module bpa_readout
  import bpa_pkg::*;
(
  // Clock, reset and clock enable
  input  wire logic                  ref_clk_i,
  input  wire logic                  resetn_i,
  input  wire logic                  ce_i,
  // Synchronizing section
  input  wire logic                  lock_i,
  input  wire logic                  frame_sync_i,
  input  wire logic                  chan_mark_i,
  input  wire logic                  burst_gate_i,
  input  wire logic                  cycle_edge_i,
  // Format programming, count minus one
  input  wire logic [ID_W-1:0]       chans_last_i,
  input  wire logic [ID_W-1:0]       frames_last_i,
  // Operator selection switches
  input  wire logic [MARKS-1:0]      mark_en_i,
  input  wire logic [15:0]           frame_en_i,
  input  wire logic [15:0]           seq_en_i,
  input  wire logic                  readout_en_i,
  // Printer handshake
  input  wire logic                  print_ack_i,
  output logic                       print_req_o,
  output logic [4*DIGITS-1:0]        print_bcd_o,
  output logic [ID_W-1:0]            print_seq_o,
  output logic [ID_W-1:0]            print_frame_o,
  output logic [ID_W-1:0]            print_chan_o,
  // Display and status
  output logic [4*DIGITS-1:0]        disp_bcd_o,
  output logic                       disp_upd_o,
  output logic                       digital_en_o,
  output logic                       lost_o
);
  bpa_state_type   state_r;
  logic [ID_W-1:0] chan_r;
  logic [ID_W-1:0] frame_r;
  logic [ID_W-1:0] seq_r;
  logic [ID_W-1:0] b_chan_r;
  logic [ID_W-1:0] b_frame_r;
  logic [ID_W-1:0] b_seq_r;
  logic [3:0]      edges_r;
  logic [4:0]      pre_r;
  logic            clr_acc;
  logic            tick;
  logic            all_nine;
  logic            done;
  logic            selected;
  logic [DIGITS:0] carry;
  logic [4*DIGITS-1:0] acc;

  // Format counters: channel wraps at the programmed count, then frame, then sequence.
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      chan_r  <= ID_RESET;
      frame_r <= ID_RESET;
      seq_r   <= ID_RESET;
    end else if (ce_i) begin
      if (frame_sync_i) begin
        chan_r  <= ID_RESET;
        frame_r <= ID_RESET;
      end else if (chan_mark_i && state_r == ST_IDLE) begin
        if (chan_r >= chans_last_i) begin
          chan_r <= ID_RESET;
          if (frame_r >= frames_last_i) begin
            frame_r <= ID_RESET;
            seq_r   <= seq_r + 4'h1;
          end else begin
            frame_r <= frame_r + 4'h1;
          end
        end else begin
          chan_r <= chan_r + 4'h1;
        end
      end
    end
  end

  // Measurement sequence: a channel mark arms, the first edge starts timing,
  // the tenth further edge ends it. Analog work continues in search mode.
  assign done = (state_r == ST_COUNT) && cycle_edge_i && (edges_r == EDGE_LAST - 4'h1);

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      state_r   <= ST_IDLE;
      edges_r   <= 4'h0;
      b_chan_r  <= ID_RESET;
      b_frame_r <= ID_RESET;
      b_seq_r   <= ID_RESET;
    end else if (ce_i) begin
      case (state_r)
        ST_IDLE: begin
          if (chan_mark_i && !frame_sync_i) begin
            b_chan_r  <= chan_r;
            b_frame_r <= frame_r;
            b_seq_r   <= seq_r;
            state_r   <= ST_ARM;
          end
        end
        ST_ARM: begin
          edges_r <= 4'h0;
          if (!burst_gate_i) begin
            state_r <= ST_IDLE;
          end else if (cycle_edge_i) begin
            state_r <= ST_COUNT;
          end
        end
        ST_COUNT: begin
          // A burst too short for ten cycles is abandoned without a result.
          if (done || !burst_gate_i) begin
            state_r <= ST_IDLE;
          end else if (cycle_edge_i) begin
            edges_r <= edges_r + 4'h1;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Ten periods at 40 ns per clock: one count per 25 clocks is one tenth of a
  // microsecond of the average, so no divider is needed.
  assign clr_acc = (state_r == ST_ARM);
  assign tick    = (state_r == ST_COUNT) && (pre_r == PRESCALE_LAST);

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      pre_r <= 5'h00;
    end else if (ce_i) begin
      if (state_r != ST_COUNT || pre_r == PRESCALE_LAST) begin
        pre_r <= 5'h00;
      end else begin
        pre_r <= pre_r + 5'h01;
      end
    end
  end

  // Saturate at all nines rather than wrap on an overlong burst.
  assign all_nine = (acc == {DIGITS{BCD_NINE}});
  assign carry[0] = tick && !all_nine;

  genvar g;
  generate
    for (g = 0; g < DIGITS; g++) begin : g_dec
      bpa_bcd_digit u_digit (
        .ref_clk_i (ref_clk_i),
        .resetn_i  (resetn_i),
        .ce_i      (ce_i),
        .clr_i     (clr_acc),
        .inc_i     (carry[g]),
        .digit_o   (acc[4*g +: 4]),
        .carry_o   (carry[g+1])
      );
    end
  endgenerate

  // 256 channel marks, 16 frame and 16 sequence switches and one master switch.
  assign selected = readout_en_i && mark_en_i[{b_frame_r, b_chan_r}] &&
                    frame_en_i[b_frame_r] && seq_en_i[b_seq_r];

  // A result arriving while the printer is still busy is shown but not printed;
  // the handshake paces the printer at whatever rate it can take.
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      print_req_o   <= 1'b0;
      print_bcd_o   <= '0;
      print_seq_o   <= ID_RESET;
      print_frame_o <= ID_RESET;
      print_chan_o  <= ID_RESET;
    end else if (ce_i) begin
      // A result in the acknowledge cycle is loaded, so no result is lost there.
      if (done && selected && (!print_req_o || print_ack_i)) begin
        print_req_o   <= 1'b1;
        print_bcd_o   <= acc;
        print_seq_o   <= b_seq_r;
        print_frame_o <= b_frame_r;
        print_chan_o  <= b_chan_r;
      end else if (print_req_o && print_ack_i) begin
        print_req_o <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      disp_bcd_o <= '0;
      disp_upd_o <= 1'b0;
    end else if (ce_i) begin
      disp_upd_o <= done && selected;
      if (done && selected) begin
        disp_bcd_o <= acc;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      digital_en_o <= 1'b0;
      lost_o       <= 1'b0;
    end else if (ce_i) begin
      digital_en_o <= lock_i;
      lost_o       <= done && selected && print_req_o && !print_ack_i;
    end
  end
endmodule
`default_nettype wire

/* testbench/bpa_readout_properties.sv */
// Port checker for the burst period readout.
`timescale 1ns/1ns
`default_nettype none
module bpa_readout_properties
  import bpa_pkg::*;
(
  // Clock and inputs
  input wire logic                ref_clk_i,
  input wire logic                resetn_i,
  input wire logic                ce_i,
  input wire logic                lock_i,
  input wire logic                print_ack_i,
  // Outputs
  input wire logic                print_req_o,
  input wire logic [4*DIGITS-1:0] print_bcd_o,
  input wire logic [ID_W-1:0]     print_seq_o,
  input wire logic [ID_W-1:0]     print_frame_o,
  input wire logic [ID_W-1:0]     print_chan_o,
  input wire logic [4*DIGITS-1:0] disp_bcd_o,
  input wire logic                disp_upd_o,
  input wire logic                digital_en_o,
  input wire logic                lost_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  function automatic bit bcd_ok(logic [4*DIGITS-1:0] v);
    for (int d = 0; d < DIGITS; d++) if (v[4*d +: 4] > BCD_NINE) return 1'b0;
    return 1'b1;
  endfunction
  property p_req_hold; print_req_o && !print_ack_i |=> print_req_o; endproperty
  property p_data_hold; print_req_o && !print_ack_i |=> $stable(print_bcd_o); endproperty
  property p_id_hold;
    print_req_o && !print_ack_i |=> $stable({print_seq_o, print_frame_o, print_chan_o});
  endproperty
  property p_req_drop;
    print_req_o && print_ack_i && ce_i |=> !print_req_o || disp_upd_o;
  endproperty
  property p_req_cause; $rose(print_req_o) |-> disp_upd_o; endproperty
  property p_upd_pulse; disp_upd_o && ce_i |=> !disp_upd_o; endproperty
  property p_disp_hold; !disp_upd_o && $past(resetn_i) |-> $stable(disp_bcd_o); endproperty
  property p_bcd; disp_upd_o |-> bcd_ok(disp_bcd_o) && bcd_ok(print_bcd_o); endproperty
  property p_mode; ce_i |=> digital_en_o == $past(lock_i); endproperty
  property p_lost; lost_o |-> $past(print_req_o) && disp_upd_o; endproperty
  a_req_hold: assert property (p_req_hold) else $error("request dropped unacked");
  a_data_hold: assert property (p_data_hold) else $error("print value moved");
  a_id_hold: assert property (p_id_hold) else $error("print ids moved");
  a_req_drop: assert property (p_req_drop) else $error("request kept after ack");
  a_req_cause: assert property (p_req_cause) else $error("request without result");
  a_upd_pulse: assert property (p_upd_pulse) else $error("update not one cycle");
  a_disp_hold: assert property (p_disp_hold) else $error("display moved");
  a_bcd: assert property (p_bcd) else $error("digit above nine");
  a_mode: assert property (p_mode) else $error("mode flag wrong");
  a_lost: assert property (p_lost) else $error("loss while idle");
  c_print: cover property (print_req_o && print_ack_i);
  c_upd: cover property (disp_upd_o);
  c_search: cover property (disp_upd_o && !digital_en_o);
endmodule
bind bpa_readout bpa_readout_properties u_props (
  .ref_clk_i     (ref_clk_i),
  .resetn_i      (resetn_i),
  .ce_i          (ce_i),
  .lock_i        (lock_i),
  .print_ack_i   (print_ack_i),
  .print_req_o   (print_req_o),
  .print_bcd_o   (print_bcd_o),
  .print_seq_o   (print_seq_o),
  .print_frame_o (print_frame_o),
  .print_chan_o  (print_chan_o),
  .disp_bcd_o    (disp_bcd_o),
  .disp_upd_o    (disp_upd_o),
  .digital_en_o  (digital_en_o),
  .lost_o        (lost_o)
);
`default_nettype wire

/* testbench/bpa_printer_model.sv */
// Printer model answering print requests after a print delay.
`timescale 1ns/1ns
`default_nettype none
module bpa_printer_model #(
  parameter int GAP = 3
) (
  input  wire logic ref_clk_i,
  input  wire logic print_req_i,
  output logic      print_ack_o
);
  initial begin
    print_ack_o = 1'b0;
    forever begin
      @(posedge ref_clk_i);
      if (print_req_i === 1'b1) begin
        // Shortened stand-in for the slow mechanical print cycle.
        repeat (GAP + $urandom_range(2)) @(posedge ref_clk_i);
        #1 print_ack_o = 1'b1;
        @(posedge ref_clk_i) #1 print_ack_o = 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
// Self-checking bench for the burst period readout.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import bpa_pkg::*;
  logic ref_clk_i = 0, resetn_i = 0, lock_i = 0, frame_sync_i = 0, ce_i = 1;
  logic chan_mark_i = 0, burst_gate_i = 0, cycle_edge_i = 0, readout_en_i = 0;
  logic [ID_W-1:0] chans_last_i = 4'h2, frames_last_i = 4'h1;
  logic [MARKS-1:0] mark_en_i = '0;
  logic [15:0] frame_en_i = '0, seq_en_i = '0;
  logic print_ack_i, print_req_o, disp_upd_o, digital_en_o, lost_o;
  logic [4*DIGITS-1:0] print_bcd_o, disp_bcd_o, bcd;
  logic [ID_W-1:0] print_seq_o, print_frame_o, print_chan_o, ch = 0, fr = 0, sq = 0;
  logic [51:0] exp_q[$];
  int error_cnt = 0, comparisons = 0, cycles = 0, k;
  bit ab;
  bpa_readout dut (
    .ref_clk_i     (ref_clk_i),
    .resetn_i      (resetn_i),
    .ce_i          (ce_i),
    .lock_i        (lock_i),
    .frame_sync_i  (frame_sync_i),
    .chan_mark_i   (chan_mark_i),
    .burst_gate_i  (burst_gate_i),
    .cycle_edge_i  (cycle_edge_i),
    .chans_last_i  (chans_last_i),
    .frames_last_i (frames_last_i),
    .mark_en_i     (mark_en_i),
    .frame_en_i    (frame_en_i),
    .seq_en_i      (seq_en_i),
    .readout_en_i  (readout_en_i),
    .print_ack_i   (print_ack_i),
    .print_req_o   (print_req_o),
    .print_bcd_o   (print_bcd_o),
    .print_seq_o   (print_seq_o),
    .print_frame_o (print_frame_o),
    .print_chan_o  (print_chan_o),
    .disp_bcd_o    (disp_bcd_o),
    .disp_upd_o    (disp_upd_o),
    .digital_en_o  (digital_en_o),
    .lost_o        (lost_o)
  );
  bpa_printer_model prn (
    .ref_clk_i   (ref_clk_i),
    .print_req_i (print_req_o),
    .print_ack_o (print_ack_i)
  );
  always #20 ref_clk_i = ~ref_clk_i;
  task print_verdict;
    $display("mismatches %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 60000) begin
      error_cnt++;
      print_verdict();
    end
  end
  always @(posedge ref_clk_i) if (disp_upd_o === 1'b1) begin
    if (exp_q.size() == 0) chk(64'h1, 64'h0);
    else chk({disp_bcd_o, print_bcd_o, print_seq_o, print_frame_o, print_chan_o},
             exp_q.pop_front());
    chk(print_req_o, 1'b1);
    chk(lost_o, 1'b0);
  end
  // Edges are one period of 25k+1 clocks apart, so ten periods give 10k tenths.
  task automatic burst(input int kk, input bit abort);
    int p;
    p = 25 * kk + 1;
    @(posedge ref_clk_i) #1 chan_mark_i = 1'b1;
    burst_gate_i = 1'b1;
    @(posedge ref_clk_i) #1 chan_mark_i = 1'b0;
    chk(digital_en_o, lock_i);
    repeat (2) @(posedge ref_clk_i);
    for (int e = 0; e < 11; e++) begin
      if (e > 0) repeat (p - 1) @(posedge ref_clk_i);
      #1 cycle_edge_i = 1'b1;
      @(posedge ref_clk_i) #1 cycle_edge_i = 1'b0;
      if (abort && e == 5) burst_gate_i = 1'b0;
    end
    repeat (4) @(posedge ref_clk_i);
    #1 burst_gate_i = 1'b0;
    repeat (12) @(posedge ref_clk_i);
    #1;
  endtask
  initial begin
    void'($urandom(32'h40136ec7));
    repeat (12) @(posedge ref_clk_i);
    #1 resetn_i = 1'b1;
    frame_sync_i = 1'b1;
    @(posedge ref_clk_i) #1 frame_sync_i = 1'b0;
    for (int i = 0; i < 20; i++) begin
      k = $urandom_range(10, 1);
      ab = (i == 2);
      lock_i = $urandom;
      mark_en_i = {8{$urandom}} | {8{$urandom}};
      frame_en_i = 16'($urandom | $urandom);
      seq_en_i = 16'($urandom | $urandom);
      readout_en_i = (i % 5 != 4);
      bcd = {12'h0, 4'(k / 10), 4'(k % 10), 4'h0};
      if (mark_en_i[{fr, ch}] && frame_en_i[fr] && seq_en_i[sq] && readout_en_i && !ab)
        exp_q.push_back({bcd, bcd, sq, fr, ch});
      burst(k, ab);
      if (ch == chans_last_i) begin
        ch = 0;
        if (fr == frames_last_i) begin
          fr = 0;
          sq++;
        end else fr++;
      end else ch++;
      if (i % 2 == 1) begin
        // While the enable is low a mark and a mode change must leave no trace.
        ce_i = 1'b0;
        lock_i = !lock_i;
        chan_mark_i = 1'b1;
        @(posedge ref_clk_i) #1 chan_mark_i = 1'b0;
        repeat ($urandom_range(3, 1)) @(posedge ref_clk_i);
        #1 chk(digital_en_o, !lock_i);
        ce_i = 1'b1;
      end
    end
    chk(exp_q.size(), 0);
    print_verdict();
  end
endmodule
`default_nettype wire
